/* logic/tstc_top.sv */
`timescale 1ns/100ps
`include "tstc_map.svh"

// Overview of operation
// - seven-bit wake threshold, bit seven reads zero
// - level and source bits pick charge target
// - discharge lasts code plus one times eight microseconds
// - first, second rates divide ten megahertz by code+1
// - third, fourth rates use same divide encoding
module tstc_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port from the serial slave
  input wire tstc_pkg::tstc_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // scan engine handshake
  input wire logic scan_cycle_start,
  input wire logic [1:0] scan_rate_slot,
  input wire logic discharge_start,
  // configuration and timing out to the front end
  output tstc_pkg::tstc_cfg_t active_cfg,
  output logic discharge_busy,
  output logic scan_tick
);
  import tstc_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q; // first stage, read only by the second
  logic rst_n; // released copy used everywhere else

  // assert at once, release two edges later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // live register fields
  // ------------------------------------------------------------
  logic [6:0] wake_q; // wake threshold value
  logic [6:0] wake_d;
  logic level_q; // charge level select
  logic level_d;
  logic refsrc_q; // reference source select
  logic refsrc_d;
  logic [2:0] dis_q; // discharge time code
  logic [2:0] dis_d;
  logic [3:0][3:0] rate_q; // four scan rate codes
  logic [3:0][3:0] rate_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // writes land in the live copy; reads return the live copy
  always_comb begin
    wake_d = wake_q;
    level_d = level_q;
    refsrc_d = refsrc_q;
    dis_d = dis_q;
    rate_d = rate_q;
    rdata_d = 8'h00;
    rvalid_d = reg_req.rd;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `TSTC_OFS_WAKE_THR: begin
          // bit seven has no storage
          wake_d = reg_req.wdata[`TSTC_WAKE_THR_MSB:0];
        end
        `TSTC_OFS_SCAN_VOLT: begin
          level_d = reg_req.wdata[`TSTC_VOLT_LEVEL_BIT];
          refsrc_d = reg_req.wdata[`TSTC_VOLT_REFSRC_BIT];
          dis_d = reg_req.wdata[`TSTC_VOLT_DIS_MSB:`TSTC_VOLT_DIS_LSB];
        end
        `TSTC_OFS_SCAN_FREQ_12: begin
          rate_d[0] = reg_req.wdata[`TSTC_RATE_LO_MSB:0];
          rate_d[1] = reg_req.wdata[7:`TSTC_RATE_HI_LSB];
        end
        `TSTC_OFS_SCAN_FREQ_34: begin
          rate_d[2] = reg_req.wdata[`TSTC_RATE_LO_MSB:0];
          rate_d[3] = reg_req.wdata[7:`TSTC_RATE_HI_LSB];
        end
        default: begin
          // offsets outside this bank are left to other banks
        end
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        `TSTC_OFS_WAKE_THR: rdata_d = {1'b0, wake_q};
        `TSTC_OFS_SCAN_VOLT: rdata_d = {level_q, dis_q, refsrc_q, 3'h0};
        `TSTC_OFS_SCAN_FREQ_12: rdata_d = {rate_q[1], rate_q[0]};
        `TSTC_OFS_SCAN_FREQ_34: rdata_d = {rate_q[3], rate_q[2]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // live register state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= `TSTC_RST_WAKE_THR;
      level_q <= `TSTC_RST_LEVEL;
      refsrc_q <= `TSTC_RST_REFSRC;
      dis_q <= `TSTC_RST_DIS_CODE;
      rate_q[0] <= `TSTC_RST_RATE_1;
      rate_q[1] <= `TSTC_RST_RATE_2;
      rate_q[2] <= `TSTC_RST_RATE_3;
      rate_q[3] <= `TSTC_RST_RATE_4;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
      level_q <= level_d;
      refsrc_q <= refsrc_d;
      dis_q <= dis_d;
      rate_q <= rate_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ------------------------------------------------------------
  // shadow copy taken at each scan cycle start
  // ------------------------------------------------------------
  tstc_cfg_t cfg_q; // what the front end runs with
  tstc_cfg_t cfg_d;

  // a mid-scan write must not bend the running scan, so hold it
  always_comb begin
    cfg_d = cfg_q;
    if (scan_cycle_start) begin
      cfg_d.wake_threshold_value = wake_q;
      cfg_d.charge_target = tstc_charge_t'({refsrc_q, level_q});
      cfg_d.discharge_code = dis_q;
      cfg_d.scan_rate = rate_q;
    end
  end

  // shadow registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q.wake_threshold_value <= `TSTC_RST_WAKE_THR;
      cfg_q.charge_target <= TSTC_CHG_0V90;
      cfg_q.discharge_code <= `TSTC_RST_DIS_CODE;
      cfg_q.scan_rate[0] <= `TSTC_RST_RATE_1;
      cfg_q.scan_rate[1] <= `TSTC_RST_RATE_2;
      cfg_q.scan_rate[2] <= `TSTC_RST_RATE_3;
      cfg_q.scan_rate[3] <= `TSTC_RST_RATE_4;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign active_cfg = cfg_q;

  // ------------------------------------------------------------
  // reference capacitor discharge timer
  // ------------------------------------------------------------
  localparam logic [9:0] DIS_STEP = 10'(`TSTC_DIS_STEP_CYC);
  tstc_dis_state_t dis_st_q; // timer state
  tstc_dis_state_t dis_st_d;
  logic [9:0] dis_cnt_q; // cycles left in the interval
  logic [9:0] dis_cnt_d;

  // interval is (code + 1) steps of eight microseconds
  always_comb begin
    dis_st_d = dis_st_q;
    dis_cnt_d = dis_cnt_q;
    case (dis_st_q)
      TSTC_DIS_IDLE: begin
        if (discharge_start) begin
          dis_st_d = TSTC_DIS_RUN;
          dis_cnt_d = 10'(DIS_STEP *
            ({7'h00, cfg_q.discharge_code} + 10'h001)) - 10'h001;
        end
      end
      TSTC_DIS_RUN: begin
        // a start while running is ignored; the interval runs out
        if (dis_cnt_q == 10'h000) begin
          dis_st_d = TSTC_DIS_IDLE;
        end else begin
          dis_cnt_d = dis_cnt_q - 10'h001;
        end
      end
      default: begin
        dis_st_d = TSTC_DIS_IDLE;
      end
    endcase
  end

  // timer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dis_st_q <= TSTC_DIS_IDLE;
      dis_cnt_q <= 10'h000;
    end else begin
      dis_st_q <= dis_st_d;
      dis_cnt_q <= dis_cnt_d;
    end
  end

  assign discharge_busy = (dis_st_q == TSTC_DIS_RUN);

  // ------------------------------------------------------------
  // scan rate divider
  // ------------------------------------------------------------
  logic [3:0] slot_code; // divide code for the chosen slot

  // only the shadow codes are used, so the ratio holds per scan
  assign slot_code = cfg_q.scan_rate[scan_rate_slot];

  // integer divide of the scan reference by code plus one
  tstc_rate_div u_rate_div (
    .clk(core_clk),
    .rst_n(rst_n),
    .run(1'b1),
    .restart(scan_cycle_start),
    .divide_code(slot_code),
    .tick(scan_tick)
  );

endmodule

/* logic/tstc_map.svh */
`ifndef TSTC_MAP_SVH
`define TSTC_MAP_SVH

// ------------------------------------------------------------
// register offsets on the serial register port
// ------------------------------------------------------------
`define TSTC_OFS_WAKE_THR 8'h18
`define TSTC_OFS_SCAN_VOLT 8'h19
`define TSTC_OFS_SCAN_FREQ_12 8'h1A
`define TSTC_OFS_SCAN_FREQ_34 8'h1B

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TSTC_WAKE_THR_MSB 6
`define TSTC_VOLT_LEVEL_BIT 7
`define TSTC_VOLT_DIS_MSB 6
`define TSTC_VOLT_DIS_LSB 4
`define TSTC_VOLT_REFSRC_BIT 3
`define TSTC_RATE_LO_MSB 3
`define TSTC_RATE_HI_LSB 4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TSTC_RST_WAKE_THR 7'h05
`define TSTC_RST_LEVEL 1'b0
`define TSTC_RST_REFSRC 1'b0
`define TSTC_RST_DIS_CODE 3'h7
`define TSTC_RST_RATE_1 4'h3
`define TSTC_RST_RATE_2 4'h7
`define TSTC_RST_RATE_3 4'h8
`define TSTC_RST_RATE_4 4'hB

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TSTC_CLK_PERIOD_NS 100
`define TSTC_DIS_STEP_NS 8000
// least time, so round up
`define TSTC_DIS_STEP_CYC \
  ((`TSTC_DIS_STEP_NS + `TSTC_CLK_PERIOD_NS - 1) / `TSTC_CLK_PERIOD_NS)

`endif

/* logic/tstc_pkg.sv */
package tstc_pkg;

  // ------------------------------------------------------------
  // charge target of the reference capacitor
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TSTC_CHG_0V90 = 2'h0,
    TSTC_CHG_1V35 = 2'h1,
    TSTC_CHG_HALF_RAIL = 2'h2,
    TSTC_CHG_3Q_RAIL = 2'h3
  } tstc_charge_t;

  // ------------------------------------------------------------
  // register port request
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tstc_req_t;

  // ------------------------------------------------------------
  // configuration seen by the scan engine
  // ------------------------------------------------------------
  typedef struct packed {
    logic [6:0] wake_threshold_value;
    tstc_charge_t charge_target;
    logic [2:0] discharge_code;
    logic [3:0][3:0] scan_rate;
  } tstc_cfg_t;

  // discharge timer states
  typedef enum logic [0:0] {
    TSTC_DIS_IDLE = 1'b0,
    TSTC_DIS_RUN = 1'b1
  } tstc_dis_state_t;

endpackage

/* logic/tstc_rate_div.sv */
`timescale 1ns/100ps
`include "tstc_map.svh"

module tstc_rate_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [3:0] divide_code,
  // output
  output logic tick
);
  import tstc_pkg::*;

  logic [3:0] cnt_q; // phase within one divided period
  logic [3:0] cnt_d;
  logic tick_q; // registered tick, one cycle wide
  logic tick_d;

  // ------------------------------------------------------------
  // divide by code plus one
  // ------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (restart || !run) begin
      // a restart realigns the phase to the new scan cycle
      cnt_d = 4'h0;
    end else if (cnt_q >= divide_code) begin
      cnt_d = 4'h0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  // plain registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

/* verification/tstc_host_model.sv */
`timescale 1ns/100ps

// --------
// host side of the register port
// --------
module tstc_host_model (
  // clock
  input wire logic core_clk,
  // register port toward the block
  output tstc_pkg::tstc_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  import tstc_pkg::*;

  // idle bus starts at zero, then shows inverted junk, never the last request
  initial reg_req = '0;

  // one write: raise after an edge, release after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // one read: answer stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

/* verification/tstc_top_assertions.sv */
`timescale 1ns/100ps

// --------
// port checker
// --------
module tstc_top_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire tstc_pkg::tstc_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // scan engine side
  input wire logic scan_cycle_start,
  input wire logic [1:0] scan_rate_slot,
  input wire logic discharge_start,
  input wire tstc_pkg::tstc_cfg_t active_cfg,
  input wire logic discharge_busy,
  input wire logic scan_tick
);
  import tstc_pkg::*;
  // busy length counter and the length promised at start
  logic [9:0] cnt_q, cnt_d, len_q, len_d;

  // length latched at start, since code may change mid-interval
  always_comb begin
    cnt_d = discharge_busy ? cnt_q + 10'h001 : 10'h000;
    len_d = len_q;
    if (discharge_start && !discharge_busy) begin
      len_d = 10'((11'(active_cfg.discharge_code) + 11'h001) * 11'h050);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 10'h000;
      len_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
      len_q <= len_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_read_answer: assert property (
    reg_req.rd |=> reg_rvalid) else $error("read not answered");
  a_answer_cause: assert property (
    reg_rvalid |-> $past(reg_req.rd)) else $error("answer without read");
  a_rdata_quiet: assert property (
    !reg_rvalid |-> reg_rdata == 8'h00) else $error("rdata not zero");
  a_wake_top_bit: assert property (
    reg_rvalid && $past(reg_req.addr) == 8'h18 |-> !reg_rdata[7])
    else $error("wake bit 7 set");
  a_volt_low_bits: assert property (
    reg_rvalid && $past(reg_req.addr) == 8'h19 |-> reg_rdata[2:0] == 3'h0)
    else $error("voltage low bits set");
  a_cfg_hold: assert property (
    !scan_cycle_start |=> $stable(active_cfg)) else $error("cfg moved");
  a_dis_start: assert property (
    discharge_start && !discharge_busy |=> discharge_busy)
    else $error("discharge not started");
  a_dis_length: assert property (
    $fell(discharge_busy) |-> cnt_q == len_q) else $error("bad length");

  c_busy_restart: cover property (discharge_busy && discharge_start);
  c_dis_done: cover property ($fell(discharge_busy));
  c_volt_write: cover property (reg_req.wr && reg_req.addr == 8'h19);
endmodule

bind tstc_top tstc_top_assertions u_tstc_top_assertions (
  .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .scan_cycle_start(scan_cycle_start), .scan_rate_slot(scan_rate_slot),
  .discharge_start(discharge_start), .active_cfg(active_cfg),
  .discharge_busy(discharge_busy), .scan_tick(scan_tick));

/* verification/tstc_top_tb.sv */
`timescale 1ns/100ps

module tstc_top_tb;
  import tstc_pkg::*;
  logic core_clk, rst_b, scan_cycle_start, discharge_start;
  logic [1:0] scan_rate_slot;
  tstc_req_t reg_req;
  logic [7:0] reg_rdata, rd_v;
  logic reg_rvalid, rv, discharge_busy, scan_tick;
  tstc_cfg_t active_cfg;
  int fails, comparisons, n;
  // read-back masks per register offset and rate codes per slot
  logic [7:0] msk [4] = '{8'h7F, 8'hF8, 8'hFF, 8'hFF};
  logic [3:0] code [4] = '{4'h0, 4'h1, 4'h5, 4'hF};

  tstc_top u_tstc_top (.core_clk(core_clk), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .scan_cycle_start(scan_cycle_start), .scan_rate_slot(scan_rate_slot),
    .discharge_start(discharge_start), .active_cfg(active_cfg),
    .discharge_busy(discharge_busy), .scan_tick(scan_tick));
  tstc_host_model u_tstc_host_model (.core_clk(core_clk),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // --------
  // helpers
  // --------
  // full width of the shadow configuration word
  task automatic chk(input string nm, input logic [27:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a wait whose bound runs out is a failure and ends the run
  task automatic guard(input int lim);
    if (n >= lim) begin
      fails++;
      $display("[FAIL] wait_bound exp %0d got %0d", lim, n);
      end_sim;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, e);
    u_tstc_host_model.rd(a, rd_v, rv);
    chk("rvalid", 28'(1'b1), 28'(rv));
    chk("rdata", 28'(e), 28'(rd_v));
  endtask

  // one-cycle scan start, which also restarts the divider
  task automatic pulse_start;
    @(posedge core_clk);
    #1 scan_cycle_start = 1'b1;
    @(posedge core_clk);
    #1 scan_cycle_start = 1'b0;
  endtask

  // one clock step, inputs change just after the edge
  task automatic step;
    @(posedge core_clk);
    #1 n++;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // --------
  // main sequence
  // --------
  initial begin
    rst_b = 1'b0;
    scan_cycle_start = 1'b0;
    discharge_start = 1'b0;
    scan_rate_slot = 2'h0;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    chk("cfg_rst", {7'h05, 2'h0, 3'h7, 16'hB873}, active_cfg);
    rd_chk(8'h18, 8'h05);
    rd_chk(8'h19, 8'h70);
    rd_chk(8'h1A, 8'h73);
    rd_chk(8'h1B, 8'hB8);
    u_tstc_host_model.wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_tstc_host_model.wr(8'h18 + 8'(i), 8'hFF);
      rd_chk(8'h18 + 8'(i), msk[i]);
    end
    // shadow must not follow the live registers until a scan starts
    chk("cfg_hold", {7'h05, 2'h0, 3'h7, 16'hB873}, active_cfg);
    u_tstc_host_model.wr(8'h1A, 8'h10);
    u_tstc_host_model.wr(8'h1B, 8'hF5);
    pulse_start;
    chk("rates", 28'(16'hF510), 28'(active_cfg.scan_rate));
    chk("wake", 28'(7'h7F), 28'(active_cfg.wake_threshold_value));
    for (int i = 0; i < 4; i++) begin
      u_tstc_host_model.wr(8'h19, {i[0], 3'h0, i[1], 3'h0});
      pulse_start;
      chk("charge", 28'(i[1:0]), 28'(active_cfg.charge_target));
    end
    // shortest and longest discharge, a refused restart in each
    for (int k = 0; k < 2; k++) begin
      if (k == 1) u_tstc_host_model.wr(8'h19, 8'h70);
      if (k == 1) pulse_start;
      @(posedge core_clk);
      #1 discharge_start = 1'b1;
      @(posedge core_clk);
      #1 discharge_start = 1'b0;
      n = 0;
      while (discharge_busy === 1'b1 && n < 1000) begin
        step;
        discharge_start = (n == 5);
      end
      discharge_start = 1'b0;
      guard(1000);
      chk("dis_len", k ? 28'd640 : 28'd80, 28'(n));
    end
    // tick spacing for each slot after a divider restart
    for (int s = 0; s < 4; s++) begin
      scan_rate_slot = 2'(s);
      pulse_start;
      n = 0;
      while (scan_tick !== 1'b1 && n < 40) step;
      guard(40);
      n = 0;
      do step; while (scan_tick !== 1'b1 && n < 40);
      guard(40);
      chk("tick_gap", 28'(code[s]) + 28'd1, 28'(n));
    end
    end_sim;
  end
endmodule
